// file: ccu_unpacker.sv
// calibration byte bank with coefficient unpacking into fields
`timescale 1ns/1ps
module ccu_unpacker #(
    parameter int NUM_BYTES = 24
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic                 prog_wr,
    input  wire logic                 prog_rd,
    input  wire logic [4:0]           prog_addr,
    input  wire logic [7:0]           prog_wdata,
    output      logic [7:0]           prog_rdata,
    output      logic                 prog_rvalid,
    input  wire logic                 soft_reset_req,
    input  wire logic                 pressure_set_sel,
    output      logic                 coef_valid,
    output      ccu_pkg::ccu_coef_t    coef,
    output      ccu_pkg::ccu_coef_tc_t coef_tc
);
    import ccu_pkg::*;

    typedef enum logic [1:0] {
        CCU_ST_LOAD = 2'b01,
        CCU_ST_RUN  = 2'b10
    } ccu_state_t;

    ccu_image_t  image_r;
    ccu_state_t  state_r;
    ccu_coef_t   coef_r;
    ccu_coef_t   coef_nxt;
    ccu_coef_tc_t tc_nxt;
    logic        mapped;

    assign mapped = (32'(prog_addr) < NUM_BYTES);

    // decode the stored image into fields for the chosen set
    function automatic ccu_coef_t decode(input ccu_image_t im,
                                         input logic psel);
        ccu_coef_t c;
        c = '0;
        c.pressure_set = psel;
        c.mode_config  = im[MODE_CONFIG_BYTE_OFS];
        c.clock_trim   = im[BOOT_CLOCK_TRIM_OFS];
        c.coarse_amp   = im[COARSE_AMP_CONTROL_OFS];
        // always-present fields
        c.fixed_gain = ccu_join10(im[FIXED_GAIN_OFFSET_HIGH_OFS][7:4],
                                  im[FIXED_GAIN_LOW_OFS]);
        c.fixed_offset = ccu_join10(im[FIXED_GAIN_OFFSET_HIGH_OFS][3:0],
                                    im[FIXED_OFFSET_LOW_OFS]);
        c.gain_temp_coefficient[0] =
            ccu_join12(im[FIRST_TC_HIGH_NIBBLES_OFS][7:4],
                       im[GAIN_TC1_LOW_OFS]);
        c.offset_temp_coefficient[0] =
            ccu_join12(im[FIRST_TC_HIGH_NIBBLES_OFS][3:0],
                       im[OFFSET_TC1_LOW_OFS]);
        c.ordinate_offset =
            ccu_join10(im[OFFSET4_ORDINATE_HIGH_OFS][3:0],
                       im[OUTPUT_ORDINATE_LOW_OFS]);
        if (psel) begin
            // pressure-set meaning of bytes 7..15 and 19..23
            c.press_coef[4] =
                ccu_join12(im[TEMP1_GAIN2_HIGH_OFS][7:4],
                           im[TEMP_PT1_OR_PCOEF5_LOW_OFS]);
            c.pressure_point[3] =
                ccu_join10(im[TEMP1_GAIN2_HIGH_OFS][3:0],
                           im[GAIN_TC2_OR_PPT5_LOW_OFS]);
            c.press_coef[3] =
                ccu_join12(im[OFFSET2_TEMP2_HIGH_OFS][7:4],
                           im[OFFSET_TC2_OR_PCOEF4_LOW_OFS]);
            c.pressure_point[2] =
                ccu_join10(im[OFFSET2_TEMP2_HIGH_OFS][3:0],
                           im[TEMP_PT2_OR_PPT4_LOW_OFS]);
            c.press_coef[2] =
                ccu_join12(im[GAIN3_OFFSET3_HIGH_OFS][7:4],
                           im[GAIN_TC3_OR_PCOEF3_LOW_OFS]);
            c.pressure_point[1] =
                ccu_join10(im[GAIN3_OFFSET3_HIGH_OFS][3:0],
                           im[OFFSET_TC3_OR_PPT3_LOW_OFS]);
            c.press_coef[1] =
                ccu_join12(im[TEMP3_GAIN4_HIGH_OFS][7:4],
                           im[TEMP_PT3_OR_PCOEF2_LOW_OFS]);
            c.pressure_point[0] =
                ccu_join10(im[TEMP3_GAIN4_HIGH_OFS][3:0],
                           im[GAIN_TC4_OR_PPT2_LOW_OFS]);
            c.press_coef[0] =
                ccu_join12(im[OFFSET4_ORDINATE_HIGH_OFS][7:4],
                           im[OFFSET_TC4_OR_PCOEF1_LOW_OFS]);
        end else begin
            // temperature-set meaning of the same bytes
            c.temperature_point[0] =
                ccu_join10(im[TEMP1_GAIN2_HIGH_OFS][7:4],
                           im[TEMP_PT1_OR_PCOEF5_LOW_OFS]);
            c.gain_temp_coefficient[1] =
                ccu_join12(im[TEMP1_GAIN2_HIGH_OFS][3:0],
                           im[GAIN_TC2_OR_PPT5_LOW_OFS]);
            c.offset_temp_coefficient[1] =
                ccu_join12(im[OFFSET2_TEMP2_HIGH_OFS][7:4],
                           im[OFFSET_TC2_OR_PCOEF4_LOW_OFS]);
            c.temperature_point[1] =
                ccu_join10(im[OFFSET2_TEMP2_HIGH_OFS][3:0],
                           im[TEMP_PT2_OR_PPT4_LOW_OFS]);
            c.gain_temp_coefficient[2] =
                ccu_join12(im[GAIN3_OFFSET3_HIGH_OFS][7:4],
                           im[GAIN_TC3_OR_PCOEF3_LOW_OFS]);
            c.offset_temp_coefficient[2] =
                ccu_join12(im[GAIN3_OFFSET3_HIGH_OFS][3:0],
                           im[OFFSET_TC3_OR_PPT3_LOW_OFS]);
            c.temperature_point[2] =
                ccu_join10(im[TEMP3_GAIN4_HIGH_OFS][7:4],
                           im[TEMP_PT3_OR_PCOEF2_LOW_OFS]);
            c.gain_temp_coefficient[3] =
                ccu_join12(im[TEMP3_GAIN4_HIGH_OFS][3:0],
                           im[GAIN_TC4_OR_PPT2_LOW_OFS]);
            c.offset_temp_coefficient[3] =
                ccu_join12(im[OFFSET4_ORDINATE_HIGH_OFS][7:4],
                           im[OFFSET_TC4_OR_PCOEF1_LOW_OFS]);
        end
        return c;
    endfunction

    // next decoded set and its two's complement view
    always_comb begin
        coef_nxt = decode(image_r, pressure_set_sel);
        for (int i = 0; i < 4; i++) begin
            tc_nxt.gain_temp_coefficient[i] =
                ccu_sm_to_tc(coef_nxt.gain_temp_coefficient[i]);
            tc_nxt.offset_temp_coefficient[i] =
                ccu_sm_to_tc(coef_nxt.offset_temp_coefficient[i]);
        end
        for (int i = 0; i < 5; i++) begin
            tc_nxt.press_coef[i] = ccu_sm_to_tc(coef_nxt.press_coef[i]);
        end
    end

    // byte store written by the programming host
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            image_r <= {CCU_NUM_BYTES{CCU_BYTE_RESET}};
        end else if (clk_en && prog_wr && mapped) begin
            image_r[prog_addr] <= prog_wdata; // unmapped writes dropped
        end
    end

    // read-back of stored bytes, one cycle latency
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata  <= 8'h00;
            prog_rvalid <= 1'b0;
        end else if (clk_en) begin
            prog_rvalid <= prog_rd;
            if (prog_rd && mapped) begin
                prog_rdata <= image_r[prog_addr];
            end else if (prog_rd) begin
                prog_rdata <= 8'h00;
            end
        end
    end

    // apply the image only after reset release or a soft reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CCU_ST_LOAD;
            coef_r  <= '0;
            coef_tc <= '0;
        end else if (clk_en) begin
            case (state_r)
                CCU_ST_LOAD: begin
                    coef_r  <= coef_nxt;
                    coef_tc <= tc_nxt;
                    state_r <= CCU_ST_RUN;
                end
                CCU_ST_RUN: begin
                    if (soft_reset_req) begin
                        state_r <= CCU_ST_LOAD;
                    end
                end
                default: begin
                    state_r <= CCU_ST_LOAD;
                end
            endcase
        end
    end

    assign coef       = coef_r;
    assign coef_valid = (state_r == CCU_ST_RUN);

endmodule

// file: ccu_pkg.sv
// constants, types and helpers for the calibration coefficient unpacker
package ccu_pkg;

    localparam int CCU_NUM_BYTES = 24;
    localparam int CCU_AW        = 5;

    // byte offsets of the calibration image
    localparam logic [4:0] MODE_CONFIG_BYTE_OFS         = 5'h00;
    localparam logic [4:0] BOOT_CLOCK_TRIM_OFS          = 5'h01;
    localparam logic [4:0] COARSE_AMP_CONTROL_OFS       = 5'h02;
    localparam logic [4:0] FIXED_GAIN_LOW_OFS           = 5'h03;
    localparam logic [4:0] FIXED_OFFSET_LOW_OFS         = 5'h04;
    localparam logic [4:0] GAIN_TC1_LOW_OFS             = 5'h05;
    localparam logic [4:0] OFFSET_TC1_LOW_OFS           = 5'h06;
    localparam logic [4:0] TEMP_PT1_OR_PCOEF5_LOW_OFS   = 5'h07;
    localparam logic [4:0] GAIN_TC2_OR_PPT5_LOW_OFS     = 5'h08;
    localparam logic [4:0] OFFSET_TC2_OR_PCOEF4_LOW_OFS = 5'h09;
    localparam logic [4:0] TEMP_PT2_OR_PPT4_LOW_OFS     = 5'h0A;
    localparam logic [4:0] GAIN_TC3_OR_PCOEF3_LOW_OFS   = 5'h0B;
    localparam logic [4:0] OFFSET_TC3_OR_PPT3_LOW_OFS   = 5'h0C;
    localparam logic [4:0] TEMP_PT3_OR_PCOEF2_LOW_OFS   = 5'h0D;
    localparam logic [4:0] GAIN_TC4_OR_PPT2_LOW_OFS     = 5'h0E;
    localparam logic [4:0] OFFSET_TC4_OR_PCOEF1_LOW_OFS = 5'h0F;
    localparam logic [4:0] OUTPUT_ORDINATE_LOW_OFS      = 5'h10;
    localparam logic [4:0] FIXED_GAIN_OFFSET_HIGH_OFS   = 5'h11;
    localparam logic [4:0] FIRST_TC_HIGH_NIBBLES_OFS    = 5'h12;
    localparam logic [4:0] TEMP1_GAIN2_HIGH_OFS         = 5'h13;
    localparam logic [4:0] OFFSET2_TEMP2_HIGH_OFS       = 5'h14;
    localparam logic [4:0] GAIN3_OFFSET3_HIGH_OFS       = 5'h15;
    localparam logic [4:0] TEMP3_GAIN4_HIGH_OFS         = 5'h16;
    localparam logic [4:0] OFFSET4_ORDINATE_HIGH_OFS    = 5'h17;

    // reset value of every stored byte (unused fields read as zero)
    localparam logic [7:0] CCU_BYTE_RESET = 8'h00;

    // sign-magnitude layout
    localparam int CCU_SM_SIGN_BIT = 11;

    typedef logic [9:0]  ccu_u10_t;
    typedef logic [11:0] ccu_sm12_t;
    typedef logic [CCU_NUM_BYTES-1:0][7:0] ccu_image_t;

    // decoded coefficient set; index 0 is the first point or coefficient
    typedef struct packed {
        logic                 pressure_set;
        logic [7:0]           mode_config;
        logic [7:0]           clock_trim;
        logic [7:0]           coarse_amp;
        ccu_u10_t             fixed_gain;
        ccu_u10_t             fixed_offset;
        logic [3:0][11:0]     gain_temp_coefficient;
        logic [3:0][11:0]     offset_temp_coefficient;
        logic [2:0][9:0]      temperature_point;
        logic [3:0][9:0]      pressure_point;   // [0]=point 2 .. [3]=point 5
        logic [4:0][11:0]     press_coef;       // [0]=coef 1 .. [4]=coef 5
        ccu_u10_t             ordinate_offset;
    } ccu_coef_t;

    // two's complement copies of every signed coefficient
    typedef struct packed {
        logic [3:0][11:0]     gain_temp_coefficient;
        logic [3:0][11:0]     offset_temp_coefficient;
        logic [4:0][11:0]     press_coef;
    } ccu_coef_tc_t;

    // unsigned 10-bit join, top bits at the nibble's low end
    function automatic ccu_u10_t ccu_join10(input logic [3:0] hi,
                                            input logic [7:0] lo);
        return {hi[1:0], lo};
    endfunction

    // 12-bit join, nibble above the low byte
    function automatic ccu_sm12_t ccu_join12(input logic [3:0] hi,
                                             input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // sign-magnitude to two's complement, both zeros give zero
    function automatic logic [11:0] ccu_sm_to_tc(input ccu_sm12_t v);
        logic [11:0] mag;
        mag = {1'b0, v[CCU_SM_SIGN_BIT-1:0]};
        if (v[CCU_SM_SIGN_BIT] && (mag != 12'h000)) begin
            return 12'(~mag + 12'h001);
        end
        return mag; // 800h lands here as zero
    endfunction

endpackage

// file: ccu_unpacker_properties.sv
// concurrent checks on the calibration byte port and decoded fields
`timescale 1ns/1ps
module ccu_unpacker_properties #(
    parameter int NUM_BYTES = 24
) (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  clk_en,
    input wire logic                  prog_wr,
    input wire logic                  prog_rd,
    input wire logic [4:0]            prog_addr,
    input wire logic [7:0]            prog_wdata,
    input wire logic [7:0]            prog_rdata,
    input wire logic                  prog_rvalid,
    input wire logic                  soft_reset_req,
    input wire logic                  pressure_set_sel,
    input wire logic                  coef_valid,
    input wire ccu_pkg::ccu_coef_t    coef,
    input wire ccu_pkg::ccu_coef_tc_t coef_tc
);
    import ccu_pkg::*;
    logic [7:0] img [0:NUM_BYTES-1];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // own sign-magnitude conversion, kept apart from the design's
    function automatic logic [11:0] tc(input logic [11:0] v);
        return v[11] ? 12'(-{1'b0, v[10:0]}) : v;
    endfunction
    // shadow of the stored byte image
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            img <= '{default: 8'h00};
        end else if (clk_en && prog_wr && prog_addr < NUM_BYTES) begin
            img[prog_addr] <= prog_wdata;
        end
    end
    AST_RD_ANSWER: assert property (clk_en && prog_rd |=> prog_rvalid)
        else $error("read not answered");
    AST_RD_PULSE: assert property (
        prog_rvalid && clk_en && !prog_rd |=> !prog_rvalid)
        else $error("read valid stretched");
    AST_RD_DATA: assert property (clk_en && prog_rd && !prog_wr
        && prog_addr < 24 |=> prog_rdata == img[$past(prog_addr)])
        else $error("read data wrong");
    AST_RD_UNMAPPED: assert property (
        clk_en && prog_rd && prog_addr > 23 |=> prog_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (coef_valid
        && !(clk_en && soft_reset_req) |=> $stable(coef) && $stable(coef_tc))
        else $error("fields moved without apply");
    AST_APPLY: assert property (
        clk_en && soft_reset_req && coef_valid |=> !coef_valid)
        else $error("apply not taken");
    AST_FIXED: assert property ($rose(coef_valid) && !$past(prog_wr)
        |-> coef.fixed_gain == {img[17][5:4], img[3]}
        && coef.fixed_offset == {img[17][1:0], img[4]})
        else $error("fixed gain or offset wrong");
    AST_TC1: assert property ($rose(coef_valid) && !$past(prog_wr)
        |-> coef.gain_temp_coefficient[0] == {img[18][7:4], img[5]}
        && coef.offset_temp_coefficient[0] == {img[18][3:0], img[6]})
        else $error("first coefficients wrong");
    AST_SEL: assert property ($rose(coef_valid)
        |-> coef.pressure_set == $past(pressure_set_sel))
        else $error("set select not latched");
    AST_CONV: assert property (coef_valid
        |-> coef_tc.press_coef[0] == tc(coef.press_coef[0])
        && coef_tc.gain_temp_coefficient[0]
           == tc(coef.gain_temp_coefficient[0]))
        else $error("conversion wrong");
    COV_PRESS: cover property ($rose(coef_valid) && coef.pressure_set);
    COV_READ: cover property (prog_rvalid);
    COV_FROZEN: cover property (!clk_en && prog_wr);
endmodule

bind ccu_unpacker ccu_unpacker_properties #(.NUM_BYTES(NUM_BYTES)) u_prop (
    .sys_clk, .rst_n, .clk_en, .prog_wr, .prog_rd, .prog_addr, .prog_wdata,
    .prog_rdata, .prog_rvalid, .soft_reset_req, .pressure_set_sel,
    .coef_valid, .coef, .coef_tc);

// file: ccu_host.sv
// programming host model driving the calibration byte port
`timescale 1ns/1ps
module ccu_host (
    input  wire logic       sys_clk,
    output      logic       prog_wr,
    output      logic       prog_rd,
    output      logic [4:0] prog_addr,
    output      logic [7:0] prog_wdata,
    output      logic       soft_reset_req,
    input  wire logic [7:0] prog_rdata,
    input  wire logic       prog_rvalid
);
    // idle port at start
    initial begin
        {prog_wr, prog_rd, soft_reset_req} = 3'h0;
        prog_addr = 5'h00;
        prog_wdata = 8'h00;
    end
    // one byte write; strobe stays up until the next call clears it
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        {prog_wr, prog_rd, prog_addr, prog_wdata} = {2'b10, a, d};
        @(negedge sys_clk);
    endtask
    // one byte read; data only taken with its valid
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        {prog_wr, prog_rd, prog_addr} = {2'b01, a};
        @(negedge sys_clk);
        d = (prog_rvalid === 1'b1) ? prog_rdata : 8'hXX;
    endtask
    // soft reset, then wait out the two-edge load
    task automatic apply();
        {prog_wr, prog_rd, soft_reset_req} = 3'b001;
        @(negedge sys_clk);
        soft_reset_req = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the calibration coefficient unpacker
`timescale 1ns/1ps
module tb_top;
    import ccu_pkg::*;
    logic         sys_clk, rst_n, clk_en, pressure_set_sel;
    logic         prog_wr, prog_rd, prog_rvalid, soft_reset_req, coef_valid;
    logic [4:0]   prog_addr;
    logic [7:0]   prog_wdata, prog_rdata;
    ccu_coef_t    coef;
    ccu_coef_tc_t coef_tc;
    int           n_fail = 0;
    int           num_checks = 0;
    int           cyc = 0;
    logic [7:0]   nib [7] = '{8'h21, 8'h8C, 8'h38, 8'h47, 8'hF2, 8'h5A, 8'h93};

    ccu_unpacker uut (.sys_clk, .rst_n, .clk_en, .prog_wr, .prog_rd,
        .prog_addr, .prog_wdata, .prog_rdata, .prog_rvalid, .soft_reset_req,
        .pressure_set_sel, .coef_valid, .coef, .coef_tc);
    ccu_host host (.sys_clk, .prog_wr, .prog_rd, .prog_addr, .prog_wdata,
        .soft_reset_req, .prog_rdata, .prog_rvalid);

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            finish_test();
        end
    end
    // field compare
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected field at %0t: %h vs %h", $time, g, e);
        end
    endtask
    // byte read compare
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        num_checks++;
        if (d !== e) begin
            n_fail++;
            $display("unexpected read at %0t: %h vs %h", $time, d, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        pressure_set_sel = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk(64'(coef_valid), 64'h1);
        host.wr(5'h18, 8'h5A);
        rdchk(5'h18, 8'h00);
        for (int i = 0; i < 17; i++) host.wr(5'(i), 8'(8'h10 + i));
        for (int i = 0; i < 7; i++) host.wr(5'(i + 17), nib[i]);
        for (int i = 0; i < 24; i++) begin
            rdchk(5'(i), i < 17 ? 8'(8'h10 + i) : nib[i - 17]);
        end
        chk(64'(coef.fixed_gain), 64'h0);
        host.apply();
        chk(64'({coef.mode_config, coef.clock_trim, coef.coarse_amp}),
            64'h101112);
        chk(64'({coef.fixed_gain, coef.fixed_offset, coef.ordinate_offset}),
            64'({10'h213, 10'h114, 10'h320}));
        chk(64'(coef.gain_temp_coefficient), 64'hA1EF1B818815);
        chk(64'(coef.offset_temp_coefficient), 64'h91F21C419C16);
        chk(64'(coef.temperature_point),
            64'({10'h11D, 10'h31A, 10'h317}));
        chk(64'(coef_tc.gain_temp_coefficient), 64'hDE28E5FE8FEB);
        chk(64'(coef_tc.offset_temp_coefficient), 64'hEE121C419BEA);
        chk(64'(coef.press_coef), 64'h0);
        pressure_set_sel = 1'b1;
        host.apply();
        chk(64'(coef.pressure_point),
            64'({10'h018, 10'h31A, 10'h21C, 10'h21E}));
        chk(64'(coef.press_coef), 64'h317419F1B51D91F);
        chk(64'(coef_tc.press_coef), 64'h3174198E551DEE1);
        chk(64'(coef.gain_temp_coefficient), 64'h815);
        chk(64'(coef.temperature_point), 64'h0);
        host.wr(5'h07, 8'h00);
        host.wr(5'h13, 8'h08);
        host.apply();
        chk(64'({coef.press_coef[4], coef.pressure_point[3]}), 64'h018);
        clk_en = 1'b0;
        host.wr(5'h03, 8'hEE);
        clk_en = 1'b1;
        rdchk(5'h03, 8'h13);
        host.apply();
        finish_test();
    end
endmodule
